/* File: hw/csb_pkg.sv */
// What this block does
// - Command byte is write-only; action bits self-clear, actuator bits hold their value.
// - Zero-coding start bit restarts acquisition and clears reference-ready flag.
// - Probe command in the 24-bit layout shifts newer latch to older and captures counter 0.
// - Command bits 5 and 6 set actuator levels and hold them.
// - Status bytes latch events and clear on read; reference-ready, pin level and SSI excepted.
// - Bit 7 of each byte latches that counter's decode fault.
// - Bit 6 of each byte latches that counter's signed range wrap.
// - Bit 5 of each byte latches that counter reaching zero.
// - Supply loss sets bit 4 in all bytes; reading any byte clears it.
// - Reference-ready reads 0 until the second distinct index pulse loads reference.
// - Interval-ready sets on interval load; clears on byte, interval or channel 1 read.
// - Reference wrap bit sets when index distance leaves the 24-bit signed range.
// - Probe-ready sets on any probe load; clears on byte, probe register, channel 1 or channel 2 read.
// - Fault line flag latches while the error line is low.
// - Warning line flag latches while the warning line is low.
// - Simultaneous access from both links sets collision flag; losing side's command write is dropped.
// - Bridge write plus channel 0 read with bridge source is no collision.
// - Second byte bit 0 shows the live probe pin level.
// - Third byte bit 0 shows SSI mode from an open serial input, filtered.
// - 48-bit shift register holds counters or bridge data by channel 0 select.
// - Decode-ok flag is 0 on a counter 0 decode error and 1 when the value is correct.
// - A read clears a latched bit only when its cause is gone.
package csb_pkg;

	localparam logic [6:0] ADDR_SHIFT_OUT   = 7'h08;
	localparam logic [6:0] ADDR_INTERVAL    = 7'h0a;
	localparam logic [6:0] ADDR_PROBE_NEW   = 7'h0c;
	localparam logic [6:0] ADDR_PROBE_OLD   = 7'h0e;
	localparam logic [6:0] ADDR_BRIDGE_LO   = 7'h20;
	localparam logic [6:0] ADDR_BRIDGE_HI   = 7'h25;
	localparam logic [6:0] ADDR_COMMAND     = 7'h30;
	localparam logic [6:0] ADDR_STATUS0     = 7'h48;
	localparam logic [6:0] ADDR_STATUS1     = 7'h49;
	localparam logic [6:0] ADDR_STATUS2     = 7'h4a;

	// Command byte bit positions
	localparam int CMD_CLR0   = 0;
	localparam int CMD_ZC     = 3;
	localparam int CMD_PROBE  = 4;
	localparam int CMD_ACTUATOR_LEVEL_0   = 5;
	localparam int CMD_ACTUATOR_LEVEL_1   = 6;

	// Status bit positions
	localparam int ST_DECODE  = 7;
	localparam int ST_WRAP    = 6;
	localparam int ST_NULL    = 5;
	localparam int ST_SUPPLY  = 4;
	localparam int ST_REFRDY  = 3;
	localparam int ST_IVLRDY  = 2;
	localparam int ST_LINEERR = 3;
	localparam int ST_REFWRAP = 1;
	localparam int ST_LINEWRN = 2;
	localparam int ST_COLL    = 1;
	localparam int ST_PRBRDY  = 0;
	localparam int ST_PINLVL  = 0;
	localparam int ST_SSI     = 0;

	localparam logic [7:0] STATUS_RESET = 8'h00;
	localparam logic [1:0] LAYOUT_24    = 2'h0;
	// Synchroniser reset: probe, serial in low; error, warning lines high
	localparam logic [3:0] PIN_SYNC_IDLE = 4'h3;

	// SSI filter: 25 us maximum at 25 MHz clock (40 ns)
	localparam int SSI_FILT_NS     = 25000;
	localparam int CLK_NS          = 40;
	localparam int SSI_FILT_CYCLES = SSI_FILT_NS / CLK_NS;

	// Register access from one serial link
	typedef struct packed {
		logic       rd;
		logic       wr;
		logic [6:0] addr;
		logic [7:0] wdata;
	} csb_acc_s;

	// Event inputs per counter
	typedef struct packed {
		logic decode_fault;
		logic wrap;
		logic null_hit;
	} csb_cnt_evt_s;

	typedef enum logic [1:0] {
		ZC_IDLE  = 2'b00,
		ZC_FIRST = 2'b01,
		ZC_DONE  = 2'b11
	} csb_zc_e;

endpackage : csb_pkg

/* File: hw/csb_bank.sv */
`timescale 1ns/100ps
module csb_bank
	import csb_pkg::*;
(
	// Clock and reset
	input  wire logic         mclk,
	input  wire logic         nrst,
	// Register accesses from both serial links (spi has priority)
	input  wire csb_acc_s     spi_acc,
	input  wire csb_acc_s     biss_acc,
	input  wire logic         biss_ch0_rd,
	input  wire logic         biss_ch1_rd,
	input  wire logic         biss_ch2_rd,
	// Read data
	output logic [7:0]        spi_rdata,
	output logic [7:0]        biss_rdata,
	// Configuration and data from the counter core
	input  wire logic         chan0_source_select,
	input  wire logic [1:0]   counter_layout_select,
	input  wire logic [47:0]  counter_values,
	input  wire logic [47:0]  host_bridge_data,
	input  wire csb_cnt_evt_s cnt_evt [3],
	input  wire logic         index_pulse,
	input  wire logic         index_distinct,
	input  wire logic         ref_range_wrap,
	input  wire logic         interval_load,
	input  wire logic         supply_loss,
	// Pins
	input  wire logic         probe_trigger_pin,
	input  wire logic         serial_in_pin,
	input  wire logic         error_in,
	input  wire logic         warning_in,
	// Outputs
	output logic [47:0]       position_shift_register,
	output logic [23:0]       probe_latch_newer,
	output logic [23:0]       probe_latch_older,
	output logic [2:0]        counter_clear_cmd,
	output logic              zero_coding_start,
	output logic              actuator_level_0,
	output logic              actuator_level_1,
	output logic              decode_ok_flag,
	output logic              probe_stale_flag
);

	////////////////////////////////////////////////////////////////////////
	// Reset release and pin synchronisers

	logic       rst_s1_reg, rst_n;
	logic [3:0] pin_s1_reg, pin_s2_reg;

	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			rst_s1_reg <= 1'b0;
			rst_n      <= 1'b0;
		end
		else
		begin
			rst_s1_reg <= 1'b1;
			rst_n      <= rst_s1_reg;
		end
	end

	// Order: probe pin, serial in, error line, warning line
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			// Idle levels, else a low line would latch a false event
			pin_s1_reg <= PIN_SYNC_IDLE;
			pin_s2_reg <= PIN_SYNC_IDLE;
		end
		else
		begin
			pin_s1_reg <= {probe_trigger_pin, serial_in_pin, error_in,
				warning_in};
			pin_s2_reg <= pin_s1_reg;
		end
	end

	wire probe_lvl = pin_s2_reg[3];
	wire sli_lvl   = pin_s2_reg[2];
	wire err_low   = !pin_s2_reg[1];
	wire wrn_low   = !pin_s2_reg[0];

	////////////////////////////////////////////////////////////////////////
	// Access arbitration

	function automatic logic is_bridge(input logic [6:0] a);
		is_bridge = (a >= ADDR_BRIDGE_LO) && (a <= ADDR_BRIDGE_HI);
	endfunction : is_bridge

	function automatic logic rd_at(input csb_acc_s acc,
		input logic [6:0] a);
		rd_at = acc.rd && (acc.addr == a);
	endfunction : rd_at

	wire spi_act  = spi_acc.rd || spi_acc.wr;
	wire biss_act = biss_acc.rd || biss_acc.wr;
	wire bridge_pair = chan0_source_select && spi_acc.wr
		&& is_bridge(spi_acc.addr) && biss_ch0_rd;
	wire collide  = spi_act && (biss_act || biss_ch0_rd)
		&& !bridge_pair;
	// The loser's command write is dropped; its reads still happen, clear status bits and give wrong data
	wire biss_ok  = biss_act && !(spi_act && biss_act);

	wire cmd_wr_spi  = spi_acc.wr && spi_acc.addr == ADDR_COMMAND;
	wire cmd_wr_biss = biss_ok && biss_acc.wr
		&& biss_acc.addr == ADDR_COMMAND;
	wire       cmd_wr = cmd_wr_spi || cmd_wr_biss;
	wire [7:0] cmd_d  = cmd_wr_spi ? spi_acc.wdata : biss_acc.wdata;

	// Status byte reads from either link
	logic [2:0] st_rd;
	always_comb
	begin
		st_rd[0] = rd_at(spi_acc, ADDR_STATUS0) || rd_at(biss_acc, ADDR_STATUS0);
		st_rd[1] = rd_at(spi_acc, ADDR_STATUS1) || rd_at(biss_acc, ADDR_STATUS1);
		st_rd[2] = rd_at(spi_acc, ADDR_STATUS2) || rd_at(biss_acc, ADDR_STATUS2);
	end
	wire ivl_rd = rd_at(spi_acc, ADDR_INTERVAL) || biss_ch1_rd;
	wire prb_rd = rd_at(spi_acc, ADDR_PROBE_NEW)
		|| rd_at(spi_acc, ADDR_PROBE_OLD) || biss_ch1_rd || biss_ch2_rd;

	////////////////////////////////////////////////////////////////////////
	// Command byte: strobes for one cycle, actuator levels held

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			counter_clear_cmd <= 3'h0;
			zero_coding_start <= 1'b0;
			actuator_level_0  <= 1'b0;
			actuator_level_1  <= 1'b0;
		end
		else
		begin
			counter_clear_cmd <= cmd_wr ? cmd_d[CMD_CLR0 +: 3] : 3'h0;
			zero_coding_start <= cmd_wr && cmd_d[CMD_ZC];
			if (cmd_wr)
			begin
				actuator_level_0 <= cmd_d[CMD_ACTUATOR_LEVEL_0];
				actuator_level_1 <= cmd_d[CMD_ACTUATOR_LEVEL_1];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Probe latches: pin edge detect on synchronised level, or command

	logic probe_prev_reg;
	wire  probe_load = (cmd_wr && cmd_d[CMD_PROBE]
		&& counter_layout_select == LAYOUT_24)
		|| (probe_lvl != probe_prev_reg);

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			probe_prev_reg    <= 1'b0;
			probe_latch_newer <= 24'h0;
			probe_latch_older <= 24'h0;
		end
		else
		begin
			probe_prev_reg <= probe_lvl;
			if (probe_load)
			begin
				probe_latch_older <= probe_latch_newer;
				probe_latch_newer <= counter_values[23:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Zero-coding sequence and reference-ready flag

	csb_zc_e zc_reg;
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			zc_reg <= ZC_IDLE;
		else if (zero_coding_start)
			zc_reg <= ZC_IDLE;
		else
			case (zc_reg)
				ZC_IDLE:  if (index_pulse) zc_reg <= ZC_FIRST;
				ZC_FIRST: if (index_pulse && index_distinct)
					zc_reg <= ZC_DONE;
				default:  zc_reg <= ZC_DONE;
			endcase
	end
	wire ref_ready = (zc_reg == ZC_DONE);

	////////////////////////////////////////////////////////////////////////
	// Latched status: set beats clear, clear only when cause is gone

	function automatic logic latch(input logic q, input logic ev,
		input logic clr);
		latch = ev || (q && !clr);
	endfunction : latch

	logic [2:0] dec_reg, wrap_reg, null_reg;
	logic       supply_reg, ivl_reg, refwrap_reg, prb_reg;
	logic       lerr_reg, lwrn_reg, coll_reg, ssi_reg;
	logic [9:0] ssi_cnt_reg;
	wire        st12_rd = st_rd[1] || st_rd[2];

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			dec_reg  <= 3'h0;
			wrap_reg <= 3'h0;
			null_reg <= 3'h0;
		end
		else
			for (int i = 0; i < 3; i++)
			begin
				dec_reg[i]  <= latch(dec_reg[i], cnt_evt[i].decode_fault,
					st_rd[i]);
				wrap_reg[i] <= latch(wrap_reg[i], cnt_evt[i].wrap,
					st_rd[i]);
				null_reg[i] <= latch(null_reg[i], cnt_evt[i].null_hit,
					st_rd[i]);
			end
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			supply_reg  <= 1'b0;
			ivl_reg     <= 1'b0;
			refwrap_reg <= 1'b0;
			prb_reg     <= 1'b0;
			lerr_reg    <= 1'b0;
			lwrn_reg    <= 1'b0;
			coll_reg    <= 1'b0;
		end
		else
		begin
			supply_reg  <= latch(supply_reg, supply_loss, |st_rd);
			ivl_reg     <= latch(ivl_reg, interval_load,
				st_rd[0] || ivl_rd);
			refwrap_reg <= latch(refwrap_reg, ref_range_wrap,
				st_rd[0]);
			prb_reg     <= latch(prb_reg, probe_load,
				st_rd[0] || prb_rd);
			lerr_reg    <= latch(lerr_reg, err_low, st12_rd);
			lwrn_reg    <= latch(lwrn_reg, wrn_low, st12_rd);
			coll_reg    <= latch(coll_reg, collide, st12_rd);
		end
	end

	// SSI select: open pin reads high; filter stays inside 25 us
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ssi_cnt_reg <= 10'h000;
			ssi_reg     <= 1'b0;
		end
		else if (sli_lvl == ssi_reg)
			ssi_cnt_reg <= 10'h000;
		else if (ssi_cnt_reg == 10'(SSI_FILT_CYCLES - 4))
		begin
			ssi_cnt_reg <= 10'h000;
			ssi_reg     <= sli_lvl;
		end
		else
			ssi_cnt_reg <= ssi_cnt_reg + 10'h001;
	end

	////////////////////////////////////////////////////////////////////////
	// Status byte images and read data

	logic [7:0] st_img [3];
	always_comb
	begin
		for (int i = 0; i < 3; i++)
		begin
			st_img[i]            = STATUS_RESET;
			st_img[i][ST_DECODE] = dec_reg[i];
			st_img[i][ST_WRAP]   = wrap_reg[i];
			st_img[i][ST_NULL]   = null_reg[i];
			st_img[i][ST_SUPPLY] = supply_reg;
		end
		st_img[0][ST_REFRDY]  = ref_ready;
		st_img[0][ST_IVLRDY]  = ivl_reg;
		st_img[0][ST_REFWRAP] = refwrap_reg;
		st_img[0][ST_PRBRDY]  = prb_reg;
		for (int i = 1; i < 3; i++)
		begin
			st_img[i][ST_LINEERR] = lerr_reg;
			st_img[i][ST_LINEWRN] = lwrn_reg;
			st_img[i][ST_COLL]    = coll_reg;
		end
		st_img[1][ST_PINLVL] = probe_lvl;
		st_img[2][ST_SSI]    = ssi_reg;
	end

	function automatic logic [7:0] rd_mux(input logic [6:0] a,
		input logic [7:0] s0, input logic [7:0] s1, input logic [7:0] s2);
		if (a == ADDR_STATUS0)
			rd_mux = s0;
		else if (a == ADDR_STATUS1)
			rd_mux = s1;
		else if (a == ADDR_STATUS2)
			rd_mux = s2;
		else
			rd_mux = 8'h00;
	endfunction : rd_mux

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			spi_rdata               <= 8'h00;
			biss_rdata              <= 8'h00;
			position_shift_register <= 48'h0;
			decode_ok_flag          <= 1'b0;
			probe_stale_flag        <= 1'b1;
		end
		else
		begin
			spi_rdata  <= rd_mux(spi_acc.addr, st_img[0], st_img[1], st_img[2]);
			// Wrong data on a lost collision, as the losing link expects
			biss_rdata <= collide ? 8'hff : rd_mux(biss_acc.addr,
				st_img[0], st_img[1], st_img[2]);
			position_shift_register <= chan0_source_select
				? host_bridge_data : counter_values;
			decode_ok_flag   <= !dec_reg[0];
			probe_stale_flag <= !prb_reg;
		end
	end

endmodule : csb_bank

/* File: testbench/csb_host_model.sv */
`timescale 1ns/100ps
module csb_host_model
	import csb_pkg::*;
(
	// Clock and answers
	input  wire logic       mclk,
	input  wire logic [7:0] spi_rdata,
	input  wire logic [7:0] biss_rdata,
	// Requests of both link masters
	output csb_acc_s        spi_acc,
	output csb_acc_s        biss_acc,
	output logic            ch0_rd
);
	// Idle links at time zero
	initial
	begin
		spi_acc = '0;
		biss_acc = '0;
		ch0_rd = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// who: bit0 spi, bit1 biss register, bit2 channel 0 read; answers are
	// taken the cycle after the accepting edge
	task acc(input logic [2:0] w, input logic r, input logic [6:0] a,
		input logic [7:0] d, output logic [7:0] sq, output logic [7:0] bq);
		@(posedge mclk);
		if (w[0])
			spi_acc <= '{r, !r, a, d};
		if (w[1])
			biss_acc <= '{r, !r, a, d};
		ch0_rd <= w[2];
		@(posedge mclk);
		spi_acc <= '0;
		biss_acc <= '0;
		ch0_rd <= 1'b0;
		#1;
		sq = spi_rdata;
		bq = biss_rdata;
	endtask : acc
endmodule : csb_host_model

/* File: testbench/csb_checker.sv */
`timescale 1ns/100ps
module csb_checker
	import csb_pkg::*;
(
	// Clock and reset
	input wire logic         mclk,
	input wire logic         nrst,
	// Inputs watched
	input wire csb_acc_s     spi_acc,
	input wire csb_acc_s     biss_acc,
	input wire logic         chan0_source_select,
	input wire logic [1:0]   counter_layout_select,
	input wire logic [47:0]  counter_values,
	input wire logic [47:0]  host_bridge_data,
	// Outputs watched
	input wire logic [7:0]   biss_rdata,
	input wire logic [47:0]  position_shift_register,
	input wire logic [23:0]  probe_latch_newer,
	input wire logic [23:0]  probe_latch_older,
	input wire logic [2:0]   counter_clear_cmd,
	input wire logic         zero_coding_start,
	input wire logic         actuator_level_0,
	input wire logic         actuator_level_1
);
	logic [1:0] up_cnt_reg;
	logic       spi_cw;
	logic       cmd_wr;

	// Command writes; a biss write loses to any spi access
	assign spi_cw = spi_acc.wr && spi_acc.addr == ADDR_COMMAND;
	assign cmd_wr = spi_cw || (biss_acc.wr && biss_acc.addr == ADDR_COMMAND
		&& !spi_acc.rd && !spi_acc.wr);

	// Edges since release, the inner reset copy lags by two flops
	always_ff @(posedge mclk or negedge nrst)
		if (!nrst)
			up_cnt_reg <= 2'h0;
		else if (up_cnt_reg != 2'h3)
			up_cnt_reg <= up_cnt_reg + 2'h1;

	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);

	////////////////////////////////////////////////////////////////////////
	clear_pulse_a:
	assert property (spi_cw |=> counter_clear_cmd == $past(spi_acc.wdata[2:0]))
		else $error("clear strobe wrong");
	strobe_drop_a:
	assert property (!cmd_wr |=> counter_clear_cmd == 3'h0 && !zero_coding_start)
		else $error("strobe did not drop");
	zc_pulse_a:
	assert property (spi_cw |=> zero_coding_start == $past(spi_acc.wdata[3]))
		else $error("zero coding strobe wrong");
	act_set_a:
	assert property (spi_cw |=>
		{actuator_level_1, actuator_level_0} == $past(spi_acc.wdata[6:5]))
		else $error("actuator level wrong");
	act_hold_a:
	assert property (!cmd_wr |=> $stable({actuator_level_1, actuator_level_0}))
		else $error("actuator level moved");
	probe_shift_a:
	assert property (spi_cw && spi_acc.wdata[4] && counter_layout_select
		== LAYOUT_24 |=> probe_latch_older == $past(probe_latch_newer)
		&& probe_latch_newer == $past(counter_values[23:0]))
		else $error("probe latch shift wrong");
	src_sel_a:
	assert property (up_cnt_reg == 2'h3 |=> position_shift_register ==
		$past(chan0_source_select ? host_bridge_data : counter_values))
		else $error("shift register source wrong");
	coll_data_a:
	assert property ((spi_acc.rd || spi_acc.wr) && (biss_acc.rd || biss_acc.wr)
		|=> biss_rdata == 8'hff)
		else $error("losing link read not marked");
endmodule : csb_checker

/* File: testbench/testbench.sv */
`timescale 1ns/100ps
module testbench
	import csb_pkg::*;
;
	logic         mclk = 1'b0, nrst = 1'b0, chsel = 1'b0, ip = 1'b0;
	logic         rwrap = 1'b0, ild = 1'b0, sloss = 1'b0, tpin = 1'b0;
	logic         err_in = 1'b1, wrn_in = 1'b1;
	logic         c1rd = 1'b0, c2rd = 1'b0, sin = 1'b0, idist = 1'b0;
	logic [1:0]   lay = 2'h0;
	logic [47:0]  cv = 48'h0, hb = 48'h0;
	csb_cnt_evt_s ev [3] = '{3'h0, 3'h0, 3'h0};
	csb_acc_s     sacc, bacc;
	logic         c0rd, c_dok, c_stale, a0, a1, zcs;
	logic [7:0]   srd, brd, q, s, b;
	logic [2:0]   clr;
	logic [23:0]  pn, po;
	logic [47:0]  psr;
	int           error_cnt = 0, comparisons = 0;

	// 25 MHz clock
	always #20 mclk = ~mclk;

	csb_host_model host_i (.mclk(mclk), .spi_rdata(srd), .biss_rdata(brd),
		.spi_acc(sacc), .biss_acc(bacc), .ch0_rd(c0rd));

	// Channel 1/2 reads and the serial input pin are driven by the bench
	csb_bank csb_bank_i (.mclk(mclk), .nrst(nrst), .spi_acc(sacc),
		.biss_acc(bacc), .biss_ch0_rd(c0rd), .biss_ch1_rd(c1rd),
		.biss_ch2_rd(c2rd), .spi_rdata(srd), .biss_rdata(brd),
		.chan0_source_select(chsel), .counter_layout_select(lay),
		.counter_values(cv), .host_bridge_data(hb), .cnt_evt(ev),
		.index_pulse(ip), .index_distinct(idist), .ref_range_wrap(rwrap),
		.interval_load(ild), .supply_loss(sloss), .probe_trigger_pin(tpin),
		.serial_in_pin(sin), .error_in(err_in), .warning_in(wrn_in),
		.position_shift_register(psr), .probe_latch_newer(pn),
		.probe_latch_older(po), .counter_clear_cmd(clr),
		.zero_coding_start(zcs), .actuator_level_0(a0),
		.actuator_level_1(a1), .decode_ok_flag(c_dok),
		.probe_stale_flag(c_stale));

	////////////////////////////////////////////////////////////////////////
	task chk(input logic [47:0] got, input logic [47:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task rd(input logic [1:0] w, input logic [6:0] a);
		host_i.acc({1'b0, w}, 1'b1, a, 8'h00, s, b);
		q = w[0] ? s : b;
	endtask : rd

	task wr(input logic [6:0] a, input logic [7:0] d);
		host_i.acc(3'b001, 1'b0, a, d, s, b);
	endtask : wr

	task final_report;
		$display("comparisons %0d mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : final_report

	////////////////////////////////////////////////////////////////////////
	task t_supply;
		rd(1, ADDR_STATUS0);
		rd(1, ADDR_STATUS1);
		@(posedge mclk);
		sloss <= 1'b1;
		@(posedge mclk);
		sloss <= 1'b0;
		rd(2, ADDR_STATUS2);
		chk(q & 8'hfe, 8'h10);
		rd(1, ADDR_STATUS0);
		chk(q, 8'h00);
		$display("supply test done");
	endtask : t_supply

	task t_cmd;
		wr(ADDR_COMMAND, 8'h29);
		chk({clr, zcs, a0}, 5'b00111);
		@(posedge mclk);
		#1;
		chk({clr, zcs, a0}, 5'b00001);
		wr(ADDR_COMMAND, 8'h46);
		chk({clr, a1, a0}, 5'b11010);
		// Command write from the other link alone is taken
		host_i.acc(3'b010, 1'b0, ADDR_COMMAND, 8'h20, s, b);
		chk({a1, a0}, 2'b01);
		$display("command test done");
	endtask : t_cmd

	task t_stat0;
		@(posedge mclk);
		ev[0] <= 3'h7;
		{ild, rwrap} <= 2'h3;
		@(posedge mclk);
		ev[0] <= 3'h0;
		{ild, rwrap} <= 2'h0;
		rd(1, ADDR_STATUS0);
		chk(q, 8'he6);
		chk(c_dok, 1'b0);
		wr(ADDR_COMMAND, 8'h01);
		chk(c_dok, 1'b1);
		// Event lands in the very cycle of the clearing read
		fork
			rd(1, ADDR_STATUS0);
			begin
				@(posedge mclk);
				ev[0] <= 3'h1;
				@(posedge mclk);
				ev[0] <= 3'h0;
			end
		join
		rd(1, ADDR_STATUS0);
		chk(q, 8'h20);
		rd(1, ADDR_STATUS0);
		chk(q, 8'h00);
		$display("status0 test done");
	endtask : t_stat0

	task t_persist;
		@(posedge mclk);
		ev[1] <= 3'h2;
		repeat (2) @(posedge mclk);
		rd(1, ADDR_STATUS1);
		rd(1, ADDR_STATUS1);
		chk(q, 8'h40);
		ev[1] <= 3'h0;
		rd(1, ADDR_STATUS1);
		rd(1, ADDR_STATUS1);
		chk(q, 8'h00);
		$display("persist test done");
	endtask : t_persist

	task t_ref;
		// Second pulse repeats the first mark; idist is driven high on the first and third
		for (int n = 0; n < 3; n++)
		begin
			@(posedge mclk);
			ip    <= 1'b1;
			idist <= (n != 1);
			@(posedge mclk);
			{ip, idist} <= 2'h0;
			rd(1, ADDR_STATUS0);
			chk(q[3], n == 2);
		end
		rd(1, ADDR_STATUS0);
		chk(q[3], 1'b1);
		wr(ADDR_COMMAND, 8'h08);
		rd(1, ADDR_STATUS0);
		chk(q[3], 1'b0);
		$display("reference test done");
	endtask : t_ref

	task t_probe;
		cv <= 48'h0000_0012_3456;
		wr(ADDR_COMMAND, 8'h10);
		cv <= 48'h0000_00ab_cdef;
		wr(ADDR_COMMAND, 8'h10);
		chk({pn, po}, 48'habcdef_123456);
		// Probe command is refused outside the 24-bit layout
		lay <= 2'h1;
		wr(ADDR_COMMAND, 8'h10);
		chk({pn, po}, 48'habcdef_123456);
		lay <= 2'h0;
		repeat (2) @(posedge mclk);
		#1;
		chk(c_stale, 1'b0);
		rd(1, ADDR_PROBE_NEW);
		repeat (2) @(posedge mclk);
		#1;
		chk(c_stale, 1'b1);
		$display("probe test done");
	endtask : t_probe

	task t_coll;
		host_i.acc(3'b011, 1'b1, ADDR_STATUS0, 8'h00, s, b);
		chk(b, 8'hff);
		rd(1, ADDR_STATUS1);
		chk(q, 8'h02);
		chsel <= 1'b1;
		hb <= 48'h1234_5678_9abc;
		host_i.acc(3'b101, 1'b0, ADDR_BRIDGE_LO, 8'h5a, s, b);
		rd(1, ADDR_STATUS1);
		chk(q, 8'h00);
		chk(psr, hb);
		chsel <= 1'b0;
		repeat (2) @(posedge mclk);
		#1;
		chk(psr, cv);
		$display("collision test done");
	endtask : t_coll

	task t_chan;
		wr(ADDR_COMMAND, 8'h10);
		@(posedge mclk);
		ild <= 1'b1;
		@(posedge mclk);
		ild  <= 1'b0;
		c2rd <= 1'b1;
		@(posedge mclk);
		c2rd <= 1'b0;
		rd(1, ADDR_STATUS0);
		chk(q, 8'h04);
		@(posedge mclk);
		ild <= 1'b1;
		@(posedge mclk);
		ild  <= 1'b0;
		c1rd <= 1'b1;
		@(posedge mclk);
		c1rd <= 1'b0;
		rd(1, ADDR_STATUS0);
		chk(q, 8'h00);
		$display("channel read test done");
	endtask : t_chan

	// The read lands in the last cycle of the 25 us window
	task t_ssi;
		@(posedge mclk);
		sin <= 1'b1;
		repeat (SSI_FILT_CYCLES - 2) @(posedge mclk);
		rd(2, ADDR_STATUS2);
		chk(q[0], 1'b1);
		sin <= 1'b0;
		repeat (SSI_FILT_CYCLES - 2) @(posedge mclk);
		rd(1, ADDR_STATUS2);
		chk(q[0], 1'b0);
		$display("ssi test done");
	endtask : t_ssi

	task t_lines;
		@(posedge mclk);
		{err_in, wrn_in, tpin} <= 3'b001;
		repeat (4) @(posedge mclk);
		{err_in, wrn_in} <= 2'b11;
		repeat (4) @(posedge mclk);
		rd(1, ADDR_STATUS1);
		chk(q, 8'h0d);
		rd(1, ADDR_STATUS2);
		chk(q & 8'hfe, 8'h00);
		$display("lines test done");
	endtask : t_lines

	////////////////////////////////////////////////////////////////////////
	// Main sequence, reset held twelve cycles
	initial
	begin
		repeat (12) @(posedge mclk);
		nrst <= 1'b1;
		repeat (3) @(posedge mclk);
		t_supply;
		t_cmd;
		t_stat0;
		t_persist;
		t_ref;
		t_probe;
		t_chan;
		t_coll;
		t_lines;
		t_ssi;
		final_report;
	end

	// Hang guard
	initial
	begin
		#2000000;
		error_cnt++;
		final_report;
	end
endmodule : testbench

bind csb_bank csb_checker csb_checker_i (.mclk(mclk), .nrst(nrst),
	.spi_acc(spi_acc), .biss_acc(biss_acc),
	.chan0_source_select(chan0_source_select),
	.counter_layout_select(counter_layout_select),
	.counter_values(counter_values), .host_bridge_data(host_bridge_data),
	.biss_rdata(biss_rdata),
	.position_shift_register(position_shift_register),
	.probe_latch_newer(probe_latch_newer),
	.probe_latch_older(probe_latch_older),
	.counter_clear_cmd(counter_clear_cmd),
	.zero_coding_start(zero_coding_start),
	.actuator_level_0(actuator_level_0),
	.actuator_level_1(actuator_level_1));
